//--- rtl/touch_defines.svh
// timing, threshold, calibration, drift and spread constants for the touch burst scheduler
// assumes a 40 MHz system clock
`ifndef TOUCH_DEFINES_SVH
`define TOUCH_DEFINES_SVH
`define CLK_MHZ            40
`define FAST_GAP_US        1000
`define FAST_GAP_CYC       (`FAST_GAP_US * `CLK_MHZ)
`define SLEEP_US           80000
`define SLEEP_CYC          (`SLEEP_US * `CLK_MHZ)
`define HEALTH_US          15
`define HEALTH_CYC         (`HEALTH_US * `CLK_MHZ)
`define PULSE_MIN_US       10
`define PULSE_MIN_CYC      (`PULSE_MIN_US * `CLK_MHZ)
`define DETECT_THRESH      16'sh000a
`define HYST_COUNTS        16'sh0002
`define CONFIRM_COUNT      3'h4
`define RECAL_MEAS         16'h0100
`define CAL_MEAS           3'h4
`define DRIFT_UP_DIV       8'h40
`define DRIFT_DN_DIV       8'h08
`define SPREAD_PCT_X10     75
`endif

//--- rtl/touch_pkg.sv
// types shared by the touch scheduler files
package touch_pkg;
    typedef enum logic [2:0]
    {
        MODE_FAST  = 3'b001,
        MODE_LOW   = 3'b010,
        MODE_PACED = 3'b100
    } run_mode_t;
    typedef enum logic [3:0]
    {
        ST_HEALTH = 4'b0001,
        ST_BURST  = 4'b0010,
        ST_WAIT   = 4'b0100,
        ST_SLEEP  = 4'b1000
    } sched_state_t;
endpackage

//--- rtl/spread_lfsr.sv
// pseudo-random dither source for the burst oscillator spread
// assumes a free running clock and synchronous reset
`timescale 1ns/100ps
`default_nettype none
module spread_lfsr
#(
    parameter int W = 8
)
(
    // clock and reset
    input  wire logic         CLK,
    input  wire logic         RST,
    // step enable and dither value
    input  wire logic         STEP,
    output logic [W-1:0]      VALUE
);
    logic [W-1:0] lfsr_q;
    logic [W-1:0] lfsr_d;

    always_comb
    begin
        lfsr_d = lfsr_q;
        if (STEP)
        begin
            lfsr_d = {lfsr_q[W-2:0], lfsr_q[W-1] ^ lfsr_q[W-3] ^ lfsr_q[W-4] ^ lfsr_q[W-5]};
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            lfsr_q <= {{(W-1){1'b0}}, 1'b1};
        end
        else
        begin
            lfsr_q <= lfsr_d;
        end
    end

    assign VALUE = lfsr_q;
endmodule
`default_nettype wire

//--- rtl/touch_burst_scheduler_detector.sv
// burst scheduling, detection, integration and drift tracking for one key
// assumes the front end returns one signed count per burst request
// Summary of operation
// R01: pin high: burst every 1 ms
// R02: pin low: sleep 80 ms per burst
// R03: low power candidate touch forces fast bursts
// R04: pin sampled at burst end; high stays fast
// R05: low sample in fast: sleep, then paced
// R06: host holds pin low beyond one burst
// R07: paced: each pin edge starts one burst
// R08: pulses longer than the pulse limit: next burst only on falling edge
// R09: pin idle 80 ms: leave paced mode
// R10: paced mode skips consecutive detect filtering
// R11: recalibration timeout counted in measurements
// R12: detect when delta reaches ten counts
// R13: release two counts below threshold
// R14: persistent detection never forces recalibration
// R15: output asserts once counter reaches four
// R16: any miss clears the counter
// R17: full calibration at reset and timeout
// R18: slew-limited drift only without detection
// R19: reference falls faster than it rises
// R20: burst oscillator dithered within 7.5 percent
// R21: output high during confirmed detection
// R22: output released 15 us before each burst
// R23: front end gives one signed count
`timescale 1ns/100ps
`default_nettype none
`include "touch_defines.svh"
module touch_burst_scheduler_detector
    import touch_pkg::*;
#(
    parameter int FAST_GAP = `FAST_GAP_CYC,
    parameter int SLEEP    = `SLEEP_CYC,
    parameter int HEALTH   = `HEALTH_CYC,
    parameter int PULSE    = `PULSE_MIN_CYC
)
(
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               RST,
    // pacing pin
    input  wire logic               PACE,
    // front end burst handshake
    output logic                    BURST_START,
    output logic [7:0]              SPREAD_TRIM,
    input  wire logic               BURST_DONE,
    input  wire logic signed [15:0] BURST_COUNT,
    // detect pin
    output logic                    DETECT_OUT,
    output logic                    DETECT_OE,
    // observation
    output logic [2:0]              RUN_MODE
);
    localparam int TW = 22;

    sched_state_t      st_q, st_d;
    run_mode_t         mode_q, mode_d;
    logic [TW-1:0]     tmr_q, tmr_d;
    logic [TW-1:0]     idle_q, idle_d;
    logic [TW-1:0]     hi_q, hi_d;
    logic              pace_q, short_q, short_d;
    logic              start_q, start_d;
    logic              pend_q, pend_d;
    logic [2:0]        cnt_q, cnt_d;
    logic              det_q, det_d;
    logic              raw_q, raw_d;
    logic signed [15:0] ref_q, ref_d;
    logic [2:0]        cal_q, cal_d;
    logic signed [19:0] acc_q, acc_d;
    logic [15:0]       recal_q, recal_d;
    logic [7:0]        up_q, up_d, dn_q, dn_d;
    logic [7:0]        dither;
    logic [7:0]        trim_q, trim_d;
    logic signed [15:0] delta;
    logic              edge_ev, hit;

    spread_lfsr #(.W(8)) u_lfsr
    (
        .CLK   (CLK),
        .RST   (RST),
        .STEP  (st_q == ST_BURST),
        .VALUE (dither)
    );

    // front end delivers a signed count; delta is rise over reference [R23]
    assign delta = BURST_COUNT - ref_q;
    // after a high past the pulse limit the next rise is ignored; falls always wake [R08]
    assign edge_ev = (PACE != pace_q) && !(short_q && PACE);

    // scheduler
    always_comb
    begin
        st_d    = st_q;
        mode_d  = mode_q;
        tmr_d   = tmr_q + 1'b1;
        idle_d  = (PACE != pace_q) ? '0 : idle_q + 1'b1;
        hi_d    = PACE ? hi_q + 1'b1 : '0;
        short_d = short_q;
        start_d = 1'b0;
        pend_d  = pend_q;
        trim_d  = trim_q;
        if (!PACE && pace_q)
        begin
            short_d = (hi_q >= TW'(PULSE));
        end
        if (PACE && !pace_q)
        begin
            short_d = 1'b0;
        end
        if (PACE && hi_q == TW'(PULSE))
        begin
            short_d = 1'b1; // [R08]
        end
        // health already leads to a burst; an edge inside the burst must not be lost
        if (mode_q == MODE_PACED && edge_ev && st_q == ST_BURST)
        begin
            pend_d = 1'b1; // [R07]
        end
        case (st_q)
            ST_HEALTH:
            begin
                if (tmr_q >= TW'(HEALTH - 1)) // [R22]
                begin
                    st_d    = ST_BURST;
                    start_d = 1'b1;
                    // spread of -8 to +7 codes around nominal trim 8'h80 [R20]
                    trim_d  = 8'h80 + {4'h0, dither[3:0]} - 8'h08;
                end
            end
            ST_BURST:
            begin
                if (BURST_DONE)
                begin
                    tmr_d  = '0;
                    if (mode_q == MODE_FAST && !PACE)
                    begin
                        mode_d = MODE_PACED; // [R05]
                        st_d   = ST_SLEEP;
                    end
                    else if (mode_q == MODE_FAST)
                    begin
                        st_d = ST_WAIT; // [R04]
                    end
                    else if (mode_q == MODE_LOW && (raw_d || cnt_d != 3'h0) && !det_d)
                    begin
                        st_d = ST_WAIT; // [R03]
                    end
                    else
                    begin
                        st_d = ST_SLEEP;
                    end
                end
            end
            ST_WAIT:
            begin
                if (tmr_q >= TW'(FAST_GAP - 1)) // [R01]
                begin
                    st_d  = ST_HEALTH;
                    tmr_d = '0;
                end
            end
            ST_SLEEP:
            begin
                if (mode_q == MODE_PACED)
                begin
                    if (pend_q || edge_ev)
                    begin
                        st_d   = ST_HEALTH; // [R07]
                        tmr_d  = '0;
                        pend_d = 1'b0;
                    end
                    else if (idle_q >= TW'(SLEEP))
                    begin
                        mode_d = PACE ? MODE_FAST : MODE_LOW; // [R09]
                        st_d   = ST_HEALTH;
                        tmr_d  = '0;
                    end
                end
                else if (tmr_q >= TW'(SLEEP - 1)) // [R02]
                begin
                    st_d  = ST_HEALTH;
                    tmr_d = '0;
                    if (PACE)
                    begin
                        mode_d = MODE_FAST;
                    end
                end
            end
            default:
            begin
                st_d  = ST_HEALTH;
                tmr_d = '0;
            end
        endcase
    end

    // detection, integration, calibration and drift
    always_comb
    begin
        cnt_d   = cnt_q;
        det_d   = det_q;
        raw_d   = raw_q;
        ref_d   = ref_q;
        cal_d   = cal_q;
        acc_d   = acc_q;
        recal_d = recal_q;
        up_d    = up_q;
        dn_d    = dn_q;
        hit     = 1'b0;
        if (st_q == ST_BURST && BURST_DONE)
        begin
            if (cal_q != 3'h0)
            begin
                // average a few bursts into a fresh reference [R17]
                acc_d = acc_q + 20'(BURST_COUNT);
                cal_d = cal_q - 1'b1;
                if (cal_q == 3'h1)
                begin
                    ref_d = 16'(acc_d >>> 2);
                    acc_d = '0;
                end
                cnt_d = 3'h0;
                det_d = 1'b0;
                raw_d = 1'b0;
            end
            else
            begin
                if (det_q)
                begin
                    hit = delta >= (`DETECT_THRESH - `HYST_COUNTS); // [R13]
                end
                else
                begin
                    hit = delta >= `DETECT_THRESH; // [R12]
                end
                raw_d = hit;
                if (!hit)
                begin
                    cnt_d = 3'h0; // [R16]
                    det_d = 1'b0;
                end
                else if (mode_q == MODE_PACED)
                begin
                    det_d = 1'b1; // [R10]
                end
                else if (cnt_q + 1'b1 >= `CONFIRM_COUNT)
                begin
                    cnt_d = `CONFIRM_COUNT;
                    det_d = 1'b1; // [R15]
                end
                else
                begin
                    cnt_d = cnt_q + 1'b1;
                end
                // timeout counts measurements, cleared while detecting [R11] [R14]
                if (det_d || hit)
                begin
                    recal_d = '0;
                end
                else if (recal_q >= `RECAL_MEAS - 1'b1)
                begin
                    recal_d = '0;
                    cal_d   = `CAL_MEAS; // [R17]
                    acc_d   = '0;
                end
                else
                begin
                    recal_d = recal_q + 1'b1;
                end
                // one count per several bursts; falling rate is faster [R18] [R19]
                if (!hit && !det_q)
                begin
                    if (delta > 0)
                    begin
                        dn_d = '0;
                        up_d = up_q + 1'b1;
                        if (up_q >= `DRIFT_UP_DIV - 1'b1)
                        begin
                            up_d  = '0;
                            ref_d = ref_q + 16'sh0001;
                        end
                    end
                    else if (delta < 0)
                    begin
                        up_d = '0;
                        dn_d = dn_q + 1'b1;
                        if (dn_q >= `DRIFT_DN_DIV - 1'b1)
                        begin
                            dn_d  = '0;
                            ref_d = ref_q - 16'sh0001;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_q    <= ST_HEALTH;
            mode_q  <= MODE_LOW;
            tmr_q   <= '0;
            idle_q  <= '0;
            hi_q    <= '0;
            pace_q  <= 1'b0;
            short_q <= 1'b0;
            start_q <= 1'b0;
            pend_q  <= 1'b0;
            trim_q  <= 8'h80;
            cnt_q   <= 3'h0;
            det_q   <= 1'b0;
            raw_q   <= 1'b0;
            ref_q   <= 16'sh0000;
            cal_q   <= `CAL_MEAS;
            acc_q   <= '0;
            recal_q <= '0;
            up_q    <= '0;
            dn_q    <= '0;
        end
        else
        begin
            st_q    <= st_d;
            mode_q  <= mode_d;
            tmr_q   <= tmr_d;
            idle_q  <= idle_d;
            hi_q    <= hi_d;
            pace_q  <= PACE;
            short_q <= short_d;
            start_q <= start_d;
            pend_q  <= pend_d;
            trim_q  <= trim_d;
            cnt_q   <= cnt_d;
            det_q   <= det_d;
            raw_q   <= raw_d;
            ref_q   <= ref_d;
            cal_q   <= cal_d;
            acc_q   <= acc_d;
            recal_q <= recal_d;
            up_q    <= up_d;
            dn_q    <= dn_d;
        end
    end

    assign BURST_START = start_q;
    assign SPREAD_TRIM = trim_q;
    assign DETECT_OUT  = det_q; // [R21]
    // pin floats only for the health window [R22]
    assign DETECT_OE   = (st_q != ST_HEALTH);
    assign RUN_MODE    = mode_q;
endmodule
`default_nettype wire

//--- bench/touch_monitor.sv
// port checker for the touch burst scheduler
// assumes the bench's shortened timing parameters
`timescale 1ns/100ps
`default_nettype none
module touch_chk
    import touch_pkg::*;
#(
    parameter int FAST_GAP = 50,
    parameter int SLEEP    = 200,
    parameter int HEALTH   = 4,
    parameter int PULSE    = 3
)
(
    // clock and reset
    input wire logic               CLK,
    input wire logic               RST,
    // pins and front end
    input wire logic               PACE,
    input wire logic               BURST_START,
    input wire logic [7:0]         SPREAD_TRIM,
    input wire logic               BURST_DONE,
    input wire logic signed [15:0] BURST_COUNT,
    input wire logic               DETECT_OUT,
    input wire logic               DETECT_OE,
    input wire logic [2:0]         RUN_MODE
);
    localparam int HW = HEALTH + 4;
    localparam int FW = FAST_GAP + HEALTH + 4;
    localparam int SW = SLEEP + HEALTH + 8;
    logic        pend_q, pend_d, pace_q;
    logic [15:0] gap_q, gap_d, idle_q, idle_d;
    always_comb
    begin
        pend_d = BURST_START | (pend_q & ~BURST_DONE);
        gap_d  = (pend_q & BURST_DONE) ? 16'h0000 : gap_q + 16'h0001;
        // idle span only matters while paced
        idle_d = (PACE != pace_q || RUN_MODE != MODE_PACED) ? 16'h0000 : idle_q + 16'h0001;
    end
    always_ff @(posedge CLK)
    begin
        pend_q <= RST ? 1'b0 : pend_d;
        gap_q  <= RST ? 16'h8000 : gap_d;
        idle_q <= RST ? 16'h0000 : idle_d;
        pace_q <= PACE;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_trim_band: assert property (SPREAD_TRIM >= 8'h78 && SPREAD_TRIM <= 8'h87)
        else $error("trim outside band");
    a_one_burst: assert property (BURST_START |-> !pend_q ##1 !BURST_START)
        else $error("burst start overlaps");
    a_health_gap: assert property (BURST_START |-> $past(DETECT_OE) == 1'b0)
        else $error("burst without health window");
    a_health_lead: assert property ($fell(DETECT_OE) |-> ##[1:HW] BURST_START)
        else $error("health window too long");
    a_fast_gap: assert property (pend_q && BURST_DONE && PACE && RUN_MODE == MODE_FAST
        |-> ##[FAST_GAP:FW] BURST_START)
        else $error("fast burst late");
    a_fast_min: assert property (BURST_START && RUN_MODE == MODE_FAST |-> gap_q >= FAST_GAP)
        else $error("fast burst early");
    a_fast_stay: assert property (pend_q && BURST_DONE && PACE && RUN_MODE == MODE_FAST
        |=> RUN_MODE == MODE_FAST)
        else $error("fast mode left");
    a_paced_exit: assert property (idle_q <= SW)
        else $error("paced mode kept too long");
    a_paced_wake: assert property ($fell(PACE) && RUN_MODE == MODE_PACED && !pend_q
        |-> ##[1:HW] BURST_START)
        else $error("paced edge did not wake");
    a_det_on_done: assert property ($changed(DETECT_OUT) |-> $past(BURST_DONE))
        else $error("detect moved without measurement");
endmodule
bind touch_burst_scheduler_detector touch_chk #(.FAST_GAP(FAST_GAP), .SLEEP(SLEEP),
    .HEALTH(HEALTH), .PULSE(PULSE)) touch_chk_i (.CLK(CLK), .RST(RST), .PACE(PACE),
    .BURST_START(BURST_START), .SPREAD_TRIM(SPREAD_TRIM), .BURST_DONE(BURST_DONE),
    .BURST_COUNT(BURST_COUNT), .DETECT_OUT(DETECT_OUT), .DETECT_OE(DETECT_OE),
    .RUN_MODE(RUN_MODE));
`default_nettype wire

//--- bench/front_end_model.sv
// behavioural charge front end: one count per burst request
// assumes requests are one-cycle pulses launched on the clock edge
`timescale 1ns/100ps
`default_nettype none
module front_end_model
(
    input wire logic               CLK,
    input wire logic               START,
    input wire logic [3:0]         DELAY,
    input wire logic signed [15:0] LEVEL,
    output logic                   DONE,
    output logic signed [15:0]     COUNT
);
    initial
    begin
        DONE  = 1'b0;
        COUNT = 16'sh0000;
        forever
        begin
            @(posedge CLK);
            // ahead of the bench, so its reads after the edge see settled values
            #1;
            DONE  = 1'b0;
            // stale count flips so it never passes for a fresh one
            COUNT = ~COUNT;
            if (START)
            begin
                repeat (DELAY) @(posedge CLK);
                #1;
                DONE  = 1'b1;
                COUNT = LEVEL;
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the touch burst scheduler
// assumes shortened timing parameters and a behavioural front end
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import touch_pkg::*;
    logic               clk, rst, pace, start, done, det, oe;
    logic [7:0]         trim;
    logic [2:0]         mode;
    logic [3:0]         dly;
    logic signed [15:0] lvl, cnt;
    int                 miscompares, compares, g, h;
    touch_burst_scheduler_detector #(.FAST_GAP(50), .SLEEP(200), .HEALTH(4), .PULSE(3))
        touch_burst_scheduler_detector_i (.CLK(clk), .RST(rst), .PACE(pace),
        .BURST_START(start), .SPREAD_TRIM(trim), .BURST_DONE(done), .BURST_COUNT(cnt),
        .DETECT_OUT(det), .DETECT_OE(oe), .RUN_MODE(mode));
    front_end_model front_end_model_i (.CLK(clk), .START(start), .DELAY(dly),
        .LEVEL(lvl), .DONE(done), .COUNT(cnt));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic tick;
        @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi)
        begin
            miscompares++;
            $display("unexpected at %0t: span %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic step(input int n, input logic signed [15:0] v);
        int t;
        lvl = v;
        repeat (n)
        begin
            t = 0;
            tick;
            while (done !== 1'b1 && t++ < 400) tick;
        end
        repeat (2) tick;
    endtask
    // g: done to next start, h: cycles with the pin released
    task automatic gap;
        g = 0;
        h = 0;
        tick;
        while (done !== 1'b1 && g++ < 400) tick;
        g = 0;
        tick;
        while (start !== 1'b1 && g < 1000)
        begin
            g++;
            if (oe === 1'b0) h++;
            tick;
        end
    endtask
    task automatic t_fast;
        dly = 4'h6;
        gap;
        chk_in(g, 50, 58);
        chk_in(h, 4, 5);
        chk(mode, MODE_FAST);
        dly = 4'h1;
    endtask
    task automatic t_integ;
        step(2, 100);
        chk({2'b00, det}, 3'h0);
        step(6, 109);
        chk({2'b00, det}, 3'h0);
        step(3, 110);
        chk({2'b00, det}, 3'h0);
        step(1, 100);
        step(3, 110);
        chk({2'b00, det}, 3'h0);
        step(1, 110);
        chk({2'b00, det}, 3'h1);
    endtask
    task automatic t_hold;
        step(300, 110);
        chk({2'b00, det}, 3'h1);
        step(3, 108);
        chk({2'b00, det}, 3'h1);
        step(1, 107);
        chk({2'b00, det}, 3'h0);
    endtask
    task automatic t_drift;
        step(12, 95);
        step(12, 105);
        step(4, 109);
        chk({2'b00, det}, 3'h1);
        step(1, 95);
    endtask
    task automatic pulse(input logic signed [15:0] v);
        int nb;
        nb = 0;
        lvl = v;
        pace = 1'b1;
        // a burst during the high phase means the rise woke the block
        repeat (10)
        begin
            tick;
            if (done === 1'b1) nb++;
        end
        pace = 1'b0;
        repeat (40)
        begin
            tick;
            if (done === 1'b1) nb++;
        end
        chk_in(nb, 1, 1);
    endtask
    task automatic t_paced;
        pace = 1'b0;
        step(1, 100);
        repeat (20) tick;
        chk(mode, MODE_PACED);
        pulse(110);
        chk({2'b00, det}, 3'h1);
        pulse(100);
        chk({2'b00, det}, 3'h0);
        repeat (240) tick;
        chk(mode, MODE_LOW);
    endtask
    task automatic t_low;
        gap;
        chk_in(g, 200, 212);
        step(1, 110);
        gap;
        chk_in(g, 50, 58);
        step(2, 110);
        chk({2'b00, det}, 3'h1);
        step(1, 100);
        gap;
        chk_in(g, 200, 212);
    endtask
    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        pace = 1'b1;
        lvl = 16'sd100;
        dly = 4'h1;
        miscompares = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        #2;
        rst = 1'b0;
        step(4, 100);
        t_fast;
        t_integ;
        t_hold;
        t_drift;
        t_paced;
        t_low;
        wrap_up;
    end
    // longest plan is near 21k cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        wrap_up;
    end
endmodule
`default_nettype wire
